// file: design/boot_stop_pkg.sv
// Contract
// (R1) Latch mode pins at reset release; single-chip only if select low and no high-voltage.
// (R2) Board requests bootstrap: high-voltage or select high, capture one high, two low.
// (R3) Boot selects: both set loader, low only RAM+1, high only any address, none reserved.
// (R4) Security bit set: erase RAM and EEPROM, option register last, before execution. Code erases only on an accepted bootstrap entry, not in single-chip mode.
// (R5) Loader routine lives at 0x03B0 through 0x03FD.
// (R6) Boot vectors and program select live at 0x7F80 through 0x7FEF.
// (R7) Loader stores bytes from 0x0050; first byte is length plus one.
// (R8) Loader uses 8N1 serial framing at 9600 baud; host matches.
// (R9) After last byte loader halts; reset keeps RAM contents.
// (R10) Jump to RAM plus one starts at 0x0051.
// (R11) Any address: port A 0xCC, port B high byte, port C low byte.
// (R12) Erased EEPROM bytes read 0xFF.
// (R13) STOP stops oscillator only while CAN controller sleeps.
// (R14) STOP entry clears CPU interrupt mask.
// (R15) STOP entry clears slow-mode bit so exit count runs nominal.
// (R16) CAN, wired-OR, external interrupt or reset restart oscillator; vectors 0x3FFA, 0x3FFE.
// (R17) After wake hold CPU 16 or 4064 internal cycles, then service wake source.
// (R18) Interrupt stacking for STOP wake happens only when leaving STOP.
// (R19) In STOP: watchdog reset, EEPROM read-only, peripherals frozen, converter off.
// (R20) In STOP all registers, memory and lines keep their state.
// (R21) Board should supply external clock with the 16-cycle option.
// (R22) Slow-mode bit adds divide-by-16 to internal clock; CAN clock exempt.
// (R23) Mode latched at reset release stays until next reset.
package boot_stop_pkg;
	localparam logic [15:0] LOADER_ROUTINE_START = 16'h03B0;
	localparam logic [15:0] LOADER_ROUTINE_END = 16'h03FD;
	localparam logic [15:0] BOOT_VECTOR_START = 16'h7F80;
	localparam logic [15:0] BOOT_VECTOR_END = 16'h7FEF;
	localparam logic [15:0] RAM_LOAD_BASE = 16'h0050;
	localparam logic [15:0] RAM_ENTRY = 16'h0051;
	localparam logic [15:0] IRQ_VECTOR = 16'h3FFA;
	localparam logic [15:0] RESET_VECTOR = 16'h3FFE;
	localparam logic [15:0] EE_BASE_DEFAULT = 16'h0100;
	localparam logic [7:0] JUMP_KEY = 8'hCC;
	localparam logic [7:0] EE_ERASED = 8'hFF;
	localparam logic [7:0] RAM_CLEARED = 8'h00;
	localparam logic [7:0] OPTION_CLEARED = 8'h00;
	localparam logic [11:0] STAB_SHORT_CYCLES = 12'h010;
	localparam logic [11:0] STAB_LONG_CYCLES = 12'hFE0;
	localparam logic [3:0] SLOW_DIV_LAST = 4'hF;
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;
	localparam int LOADER_BAUD = 9600;
	localparam int LOADER_XTAL_HZ = 4000000;
	localparam int SYNC_WIDTH = 32;

	typedef enum logic [1:0] {
		BF_RESERVED = 2'b00,
		BF_RAM_PLUS1 = 2'b01,
		BF_ANY_ADDR = 2'b10,
		BF_LOADER = 2'b11
	} boot_func_t;

	typedef enum logic [1:0] {
		MEM_RAM = 2'b00,
		MEM_EEPROM = 2'b01,
		MEM_OPTION = 2'b10
	} mem_sel_t;

	typedef enum logic [3:0] {
		ST_SETTLE = 4'b0000,
		ST_ERASE_RAM = 4'b0001,
		ST_ERASE_EE = 4'b0010,
		ST_ERASE_OPT = 4'b0011,
		ST_STABILISE = 4'b0100,
		ST_RUN = 4'b0101,
		ST_LOAD = 4'b0110,
		ST_HALT = 4'b0111,
		ST_STOP = 4'b1000,
		ST_RESERVED = 4'b1001
	} state_t;
endpackage : boot_stop_pkg

// file: design/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk, // Clock
	input wire logic reset_n, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic [WIDTH-1:0] d, // Asynchronous inputs
	output logic [WIDTH-1:0] q // Synchronised inputs
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_t;

	sync_t r;
	sync_t n;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("pin_sync width must be positive");
		end
	endgenerate

	always_comb begin
		n = r;
		n.s1 = d;
		n.s2 = r.s1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	assign q = r.s2;
endmodule : pin_sync
`default_nettype wire

// file: design/slow_divider.sv
`timescale 1ns/1ns
`default_nettype none
module slow_divider import boot_stop_pkg::*; (
	input wire logic clk, // Clock
	input wire logic reset_n, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic slow, // Slow-mode bit
	output logic tick, // Internal cycle strobe
	output logic can_tick // CAN controller strobe, never divided
);
	typedef struct packed {
		logic [3:0] cnt;
		logic tick;
		logic can_tick;
	} div_t;

	div_t r;
	div_t n;

	always_comb begin
		n = r;
		n.can_tick = 1'b1; // R22
		if (slow) begin
			n.tick = (r.cnt == SLOW_DIV_LAST); // R22
			n.cnt = r.cnt + 4'h1;
		end else begin
			n.tick = 1'b1;
			n.cnt = 4'h0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	assign tick = r.tick;
	assign can_tick = r.can_tick;
endmodule : slow_divider
`default_nettype wire

// file: design/boot_mode_and_stop_control.sv
`timescale 1ns/1ns
`default_nettype none
module boot_mode_and_stop_control import boot_stop_pkg::*; #(
	parameter int RAM_BYTES = 352,
	parameter int EE_BYTES = 256,
	parameter logic [15:0] EE_BASE = EE_BASE_DEFAULT,
	parameter bit LONG_STAB = 1'b1
) (
	input wire logic CLK, // 125 MHz clock
	input wire logic RESET_N, // Async reset, active low
	input wire logic CE, // Clock enable, freezes all state when low
	input wire logic MODE_SELECT_PIN, // Mode select pin
	input wire logic IRQ_HIGH_VOLTAGE, // Interrupt pin high-voltage detector
	input wire logic CAPTURE_INPUT_ONE, // Capture input one pin
	input wire logic CAPTURE_INPUT_TWO, // Capture input two pin
	input wire logic BOOT_SELECT_LOW, // Boot function select, low bit
	input wire logic BOOT_SELECT_HIGH, // Boot function select, high bit
	input wire logic [7:0] PORT_A, // Port A pins
	input wire logic [7:0] PORT_B, // Port B pins, jump target high byte
	input wire logic [7:0] PORT_C, // Port C pins, jump target low byte
	input wire logic EXT_IRQ, // External interrupt pin event
	input wire logic WOR_IRQ, // Wired-OR port interrupt pin event
	input wire logic CAN_IRQ, // CAN controller interrupt
	input wire logic CAN_ASLEEP, // CAN controller in sleep state
	input wire logic SECURITY_BIT, // Security bit from option register
	input wire logic STOP_REQ, // CPU executes STOP, one-cycle pulse
	input wire logic SLOW_MODE_WRITE, // Write strobe for slow-mode bit
	input wire logic SLOW_MODE_DATA, // Value written to slow-mode bit
	input wire logic RX_VALID, // Received serial byte strobe
	input wire logic [7:0] RX_DATA, // Received serial byte
	output logic SINGLE_CHIP, // Single-chip mode latched
	output logic BOOT_MODE, // Bootstrap mode latched
	output logic [1:0] BOOT_FUNC, // Latched boot function
	output logic CPU_HOLD, // CPU held
	output logic START_VALID, // Start address strobe
	output logic [15:0] START_ADDR, // Address CPU starts from
	output logic WAKE_STACK, // Stack interrupt frame now
	output logic CLEAR_IMASK, // Clear CPU interrupt mask
	output logic OSC_ENABLE, // Oscillator running
	output logic SLOW_MODE_BIT, // Slow-mode bit
	output logic INTERNAL_TICK, // Internal cycle strobe
	output logic CAN_TICK, // CAN clock strobe
	output logic WATCHDOG_CLEAR, // Watchdog held reset
	output logic EEPROM_READ_ONLY, // EEPROM write lock
	output logic PERIPH_FREEZE, // Serial, timer, modulator, converter frozen
	output logic IO_HOLD, // I/O lines hold state
	output logic SCI_LOADER_CFG, // Serial port in loader 8N1 setup
	output logic MEM_WE, // Memory write strobe
	output logic [1:0] MEM_SEL, // Memory target
	output logic [15:0] MEM_ADDR, // Memory address
	output logic [7:0] MEM_WDATA, // Memory write data
	output logic LOADER_HALTED // Loader finished, waiting
);
	typedef struct packed {
		state_t st;
		logic [1:0] settle;
		logic single;
		logic boot;
		boot_func_t func;
		logic [15:0] target;
		logic [11:0] stab;
		logic wake_irq;
		logic [15:0] idx;
		logic [7:0] count;
		logic slow;
		logic stopped;
		logic cpu_hold;
		logic start_valid;
		logic [15:0] start_addr;
		logic wake_stack;
		logic clr_imask;
		logic osc_en;
		logic sci_cfg;
		logic mem_we;
		mem_sel_t mem_sel;
		logic [15:0] mem_addr;
		logic [7:0] mem_wdata;
		logic halted;
	} ctl_t;

	localparam logic [11:0] STAB_LIMIT = LONG_STAB ? STAB_LONG_CYCLES : STAB_SHORT_CYCLES;
	localparam logic [15:0] RAM_LAST = 16'(RAM_BYTES - 1);
	localparam logic [15:0] EE_LAST = 16'(EE_BYTES - 1);

	generate
		if (RAM_BYTES < 1 || RAM_BYTES > 65536 - 80) begin : g_bad_ram
			$error("RAM_BYTES out of range");
		end
		if (EE_BYTES < 1 || EE_BYTES > 65536) begin : g_bad_ee
			$error("EE_BYTES out of range");
		end
		if (int'(EE_BASE) + EE_BYTES > 65536) begin : g_bad_ee_span
			$error("EEPROM window runs past the address space");
		end
	endgenerate

	logic [SYNC_WIDTH-1:0] pins_raw;
	logic [SYNC_WIDTH-1:0] pins;
	logic mds_s;
	logic hv_s;
	logic cap1_s;
	logic cap2_s;
	logic bsl_s;
	logic bsh_s;
	logic [7:0] pa_s;
	logic [7:0] pb_s;
	logic [7:0] pc_s;
	logic ext_s;
	logic wor_s;
	logic tick;
	logic can_tick;

	assign pins_raw = {MODE_SELECT_PIN, IRQ_HIGH_VOLTAGE, CAPTURE_INPUT_ONE, CAPTURE_INPUT_TWO,
		BOOT_SELECT_LOW, BOOT_SELECT_HIGH, PORT_A, PORT_B, PORT_C, EXT_IRQ, WOR_IRQ};
	assign {mds_s, hv_s, cap1_s, cap2_s, bsl_s, bsh_s, pa_s, pb_s, pc_s, ext_s, wor_s} = pins;

	pin_sync #(
		.WIDTH(SYNC_WIDTH)
	) u_sync (
		.clk(CLK),
		.reset_n(RESET_N),
		.ce(CE),
		.d(pins_raw),
		.q(pins)
	);

	ctl_t r;
	ctl_t n;

	slow_divider u_div (
		.clk(CLK),
		.reset_n(RESET_N),
		.ce(CE),
		.slow(r.slow),
		.tick(tick),
		.can_tick(can_tick)
	);

	always_comb begin
		logic not_single;
		logic boot_ok;
		logic key_ok;
		boot_func_t f;
		logic last_byte;
		not_single = 1'b0;
		boot_ok = 1'b0;
		key_ok = 1'b0;
		f = BF_RESERVED;
		last_byte = 1'b0;
		n = r;
		n.start_valid = 1'b0;
		n.wake_stack = 1'b0;
		n.clr_imask = 1'b0;
		n.mem_we = 1'b0;
		if (SLOW_MODE_WRITE) begin
			n.slow = SLOW_MODE_DATA;
		end
		unique case (r.st)
			ST_SETTLE: begin
				if (r.settle == SETTLE_CYCLES) begin
					not_single = mds_s || hv_s;
					boot_ok = not_single && cap1_s && !cap2_s; // R2
					f = boot_func_t'({bsh_s, bsl_s}); // R3
					key_ok = (pa_s == JUMP_KEY); // R11
					n.single = !not_single; // R1
					n.boot = boot_ok;
					n.func = f; // R23
					unique case (f)
						BF_LOADER: n.target = LOADER_ROUTINE_START; // R5
						BF_RAM_PLUS1: n.target = RAM_ENTRY; // R10
						BF_ANY_ADDR: n.target = {pb_s, pc_s}; // R11
						BF_RESERVED: n.target = BOOT_VECTOR_START; // R6
					endcase
					if (!not_single) begin
						n.target = RESET_VECTOR;
						n.st = ST_STABILISE;
					end else if (!boot_ok || f == BF_RESERVED || (f == BF_ANY_ADDR && !key_ok)) begin
						n.st = ST_RESERVED;
					end else if (SECURITY_BIT) begin
						n.idx = 16'h0000;
						n.st = ST_ERASE_RAM; // R4
					end else begin
						n.st = ST_STABILISE;
					end
				end else begin
					n.settle = r.settle + 2'h1;
				end
			end
			ST_ERASE_RAM: begin
				n.mem_we = 1'b1; // R4
				n.mem_sel = MEM_RAM;
				n.mem_addr = RAM_LOAD_BASE + r.idx;
				n.mem_wdata = RAM_CLEARED;
				if (r.idx == RAM_LAST) begin
					n.idx = 16'h0000;
					n.st = ST_ERASE_EE;
				end else begin
					n.idx = r.idx + 16'h0001;
				end
			end
			ST_ERASE_EE: begin
				n.mem_we = 1'b1; // R4
				n.mem_sel = MEM_EEPROM;
				n.mem_addr = EE_BASE + r.idx;
				n.mem_wdata = EE_ERASED; // R12
				if (r.idx == EE_LAST) begin
					n.idx = 16'h0000;
					n.st = ST_ERASE_OPT;
				end else begin
					n.idx = r.idx + 16'h0001;
				end
			end
			ST_ERASE_OPT: begin
				// Option register goes last so the security bit stays set until memory is clean
				n.mem_we = 1'b1; // R4
				n.mem_sel = MEM_OPTION;
				n.mem_addr = 16'h0000;
				n.mem_wdata = OPTION_CLEARED;
				n.st = ST_STABILISE;
			end
			ST_STABILISE: begin
				n.cpu_hold = 1'b1;
				if (tick) begin
					if (r.stab == STAB_LIMIT - 12'h001) begin // R17
						n.stab = 12'h000;
						n.cpu_hold = 1'b0;
						n.start_valid = 1'b1;
						n.start_addr = r.wake_irq ? IRQ_VECTOR : r.target; // R16
						n.wake_stack = r.wake_irq; // R18
						n.wake_irq = 1'b0;
						if (r.boot && r.func == BF_LOADER && !r.wake_irq) begin
							n.idx = 16'h0000;
							n.sci_cfg = 1'b1; // R8
							n.st = ST_LOAD;
						end else begin
							n.st = ST_RUN;
						end
					end else begin
						n.stab = r.stab + 12'h001;
					end
				end
			end
			ST_RUN: begin
				if (STOP_REQ && CAN_ASLEEP) begin // R13
					n.osc_en = 1'b0;
					n.stopped = 1'b1; // R19 R20
					n.clr_imask = 1'b1; // R14
					n.slow = 1'b0; // R15
					n.cpu_hold = 1'b1;
					n.st = ST_STOP;
				end
			end
			ST_LOAD: begin
				if (RX_VALID) begin
					n.mem_we = 1'b1; // R7
					n.mem_sel = MEM_RAM;
					n.mem_addr = RAM_LOAD_BASE + {8'h00, r.idx[7:0]};
					n.mem_wdata = RX_DATA;
					if (r.idx[7:0] == 8'h00) begin
						n.count = RX_DATA;
						last_byte = (RX_DATA <= 8'h01);
					end else begin
						last_byte = ((r.idx[7:0] + 8'h01) >= r.count);
					end
					n.idx = r.idx + 16'h0001;
					if (last_byte) begin
						n.halted = 1'b1; // R9
						n.st = ST_HALT;
					end
				end
			end
			ST_HALT: begin
				n.halted = 1'b1; // R9
			end
			ST_STOP: begin
				if (CAN_IRQ || wor_s || ext_s) begin // R16
					n.osc_en = 1'b1;
					n.stopped = 1'b0;
					n.wake_irq = 1'b1;
					n.stab = 12'h000;
					n.st = ST_STABILISE;
				end
			end
			ST_RESERVED: begin
				n.cpu_hold = 1'b1;
			end
			default: begin
				n.st = ST_RESERVED;
			end
		endcase
	end

	// RAM is not cleared by reset itself, so a loaded program survives for the next boot function unless SECURITY_BIT sends it through ST_ERASE_RAM
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r <= '0;
			r.cpu_hold <= 1'b1;
			r.osc_en <= 1'b1;
		end else if (CE) begin
			r <= n;
		end
	end

	assign SINGLE_CHIP = r.single;
	assign BOOT_MODE = r.boot;
	assign BOOT_FUNC = r.func;
	assign CPU_HOLD = r.cpu_hold;
	assign START_VALID = r.start_valid;
	assign START_ADDR = r.start_addr;
	assign WAKE_STACK = r.wake_stack;
	assign CLEAR_IMASK = r.clr_imask;
	assign OSC_ENABLE = r.osc_en;
	assign SLOW_MODE_BIT = r.slow;
	assign INTERNAL_TICK = tick;
	assign CAN_TICK = can_tick;
	assign WATCHDOG_CLEAR = r.stopped;
	assign EEPROM_READ_ONLY = r.stopped;
	assign PERIPH_FREEZE = r.stopped;
	assign IO_HOLD = r.stopped;
	assign SCI_LOADER_CFG = r.sci_cfg;
	assign MEM_WE = r.mem_we;
	assign MEM_SEL = r.mem_sel;
	assign MEM_ADDR = r.mem_addr;
	assign MEM_WDATA = r.mem_wdata;
	assign LOADER_HALTED = r.halted;
endmodule : boot_mode_and_stop_control
`default_nettype wire

// file: sim/board_host.sv
`timescale 1ns/1ns
`default_nettype none
module board_host (
	input wire logic CLK, // Clock
	output logic MODE_SELECT_PIN, // Mode select strap
	output logic IRQ_HIGH_VOLTAGE, // Interrupt pin at twice supply
	output logic CAPTURE_INPUT_ONE, // Capture one strap
	output logic CAPTURE_INPUT_TWO, // Capture two strap
	output logic BOOT_SELECT_LOW, // Boot select low strap
	output logic BOOT_SELECT_HIGH, // Boot select high strap
	output logic [7:0] PORT_A, // Port A
	output logic [7:0] PORT_B, // Port B
	output logic [7:0] PORT_C, // Port C
	output logic RX_VALID, // Byte strobe
	output logic [7:0] RX_DATA // Byte
);
	initial begin
		{MODE_SELECT_PIN, IRQ_HIGH_VOLTAGE, CAPTURE_INPUT_ONE, CAPTURE_INPUT_TWO} = 4'h0;
		{BOOT_SELECT_LOW, BOOT_SELECT_HIGH, RX_VALID} = 3'h0;
		{PORT_A, PORT_B, PORT_C} = 24'h00_0000;
		RX_DATA = 8'h5A;
	end
	// Straps change on an edge and then stand through reset release
	task automatic strap(input logic [5:0] p, input logic [23:0] abc);
		@(posedge CLK);
		{MODE_SELECT_PIN, IRQ_HIGH_VOLTAGE, CAPTURE_INPUT_ONE, CAPTURE_INPUT_TWO} <= p[5:2];
		{BOOT_SELECT_LOW, BOOT_SELECT_HIGH} <= p[1:0];
		{PORT_A, PORT_B, PORT_C} <= abc;
	endtask : strap
	// One whole 8N1 frame per strobe; released data turns over
	task automatic send(input logic [7:0] b);
		@(posedge CLK);
		RX_VALID <= 1'b1;
		RX_DATA <= b;
		@(posedge CLK);
		RX_VALID <= 1'b0;
		RX_DATA <= ~b;
	endtask : send
endmodule : board_host
`default_nettype wire

// file: sim/boot_stop_checker.sv
`timescale 1ns/1ns
`default_nettype none
module boot_stop_checker import boot_stop_pkg::*; #(
	parameter bit LONG_STAB = 1'b1
) (
	input wire logic CLK, // Clock
	input wire logic RESET_N, // Reset, active low
	input wire logic CE, // Clock enable
	input wire logic STOP_REQ, // STOP request
	input wire logic CAN_ASLEEP, // CAN asleep
	input wire logic CAN_IRQ, // CAN interrupt
	input wire logic SINGLE_CHIP, // Single-chip mode
	input wire logic BOOT_MODE, // Bootstrap mode
	input wire logic CPU_HOLD, // CPU held
	input wire logic START_VALID, // Start strobe
	input wire logic [15:0] START_ADDR, // Start address
	input wire logic WAKE_STACK, // Stack on wake
	input wire logic CLEAR_IMASK, // Clear mask
	input wire logic OSC_ENABLE, // Oscillator on
	input wire logic SLOW_MODE_BIT, // Slow-mode bit
	input wire logic CAN_TICK, // CAN strobe
	input wire logic WATCHDOG_CLEAR, // Watchdog held
	input wire logic EEPROM_READ_ONLY, // EEPROM locked
	input wire logic PERIPH_FREEZE, // Peripherals frozen
	input wire logic IO_HOLD, // Lines held
	input wire logic MEM_WE, // Memory write
	input wire logic [1:0] MEM_SEL, // Memory target
	input wire logic [7:0] MEM_WDATA // Write data
);
	localparam int LIM = LONG_STAB ? 4064 : 16;
	logic [12:0] wake_cnt_r;
	// Cycles with the oscillator running and the CPU still held
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wake_cnt_r <= 13'h0000;
		end else if (!OSC_ENABLE) begin
			wake_cnt_r <= 13'h0000;
		end else if (CPU_HOLD && CE) begin
			wake_cnt_r <= wake_cnt_r + 13'h0001;
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	a_stop_needs_sleep: assert property ($fell(OSC_ENABLE) |-> $past(STOP_REQ) && $past(CAN_ASLEEP))
		else $error("oscillator stopped without sleeping CAN");
	a_imask_on_entry: assert property (CLEAR_IMASK |-> $fell(OSC_ENABLE))
		else $error("mask clear outside STOP entry");
	a_slow_cleared: assert property ($fell(OSC_ENABLE) |-> !SLOW_MODE_BIT)
		else $error("slow bit kept on STOP entry");
	a_stop_freeze: assert property (!OSC_ENABLE |-> CPU_HOLD && WATCHDOG_CLEAR && EEPROM_READ_ONLY && PERIPH_FREEZE && IO_HOLD)
		else $error("stopped state not frozen");
	a_irq_restart: assert property (!OSC_ENABLE && CAN_IRQ && CE |=> OSC_ENABLE)
		else $error("CAN interrupt did not restart oscillator");
	a_wake_vector: assert property (WAKE_STACK |-> START_VALID && !CPU_HOLD && START_ADDR == IRQ_VECTOR)
		else $error("wake stacking without interrupt vector");
	a_wake_delay: assert property (WAKE_STACK |-> int'(wake_cnt_r) >= LIM - 2 && int'(wake_cnt_r) <= LIM + 2)
		else $error("wake stabilisation length wrong");
	a_mode_latched: assert property ($past(SINGLE_CHIP) || $past(BOOT_MODE) |-> $stable(SINGLE_CHIP) && $stable(BOOT_MODE))
		else $error("latched mode changed");
	a_option_last: assert property (MEM_WE && MEM_SEL == MEM_OPTION |-> $past(MEM_WE) && $past(MEM_SEL) == MEM_EEPROM && CPU_HOLD)
		else $error("option register not erased last");
	a_ee_erased: assert property (MEM_WE && MEM_SEL == MEM_EEPROM |-> MEM_WDATA == EE_ERASED)
		else $error("EEPROM erase value wrong");
	a_can_undivided: assert property (SLOW_MODE_BIT |-> CAN_TICK)
		else $error("CAN clock divided in slow mode");
endmodule : boot_stop_checker

bind boot_mode_and_stop_control boot_stop_checker #(.LONG_STAB(LONG_STAB)) u_chk (
	.CLK, .RESET_N, .CE, .STOP_REQ, .CAN_ASLEEP, .CAN_IRQ, .SINGLE_CHIP, .BOOT_MODE, .CPU_HOLD,
	.START_VALID, .START_ADDR, .WAKE_STACK, .CLEAR_IMASK, .OSC_ENABLE, .SLOW_MODE_BIT, .CAN_TICK,
	.WATCHDOG_CLEAR, .EEPROM_READ_ONLY, .PERIPH_FREEZE, .IO_HOLD, .MEM_WE, .MEM_SEL, .MEM_WDATA
);
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import boot_stop_pkg::*;
	logic CLK, RESET_N, CE, EXT_IRQ, WOR_IRQ, CAN_IRQ, CAN_ASLEEP, SECURITY_BIT, STOP_REQ, SLOW_MODE_WRITE;
	logic SLOW_MODE_DATA, MODE_SELECT_PIN, IRQ_HIGH_VOLTAGE, CAPTURE_INPUT_ONE, CAPTURE_INPUT_TWO, BOOT_SELECT_LOW;
	logic BOOT_SELECT_HIGH, RX_VALID, SINGLE_CHIP, BOOT_MODE, CPU_HOLD, START_VALID, WAKE_STACK, CLEAR_IMASK;
	logic OSC_ENABLE, SLOW_MODE_BIT, INTERNAL_TICK, CAN_TICK, WATCHDOG_CLEAR, EEPROM_READ_ONLY, PERIPH_FREEZE;
	logic IO_HOLD, SCI_LOADER_CFG, MEM_WE, LOADER_HALTED;
	logic [1:0] BOOT_FUNC, MEM_SEL;
	logic [7:0] PORT_A, PORT_B, PORT_C, RX_DATA, MEM_WDATA;
	logic [15:0] START_ADDR, MEM_ADDR;
	logic [25:0] wq[$];
	int err_count, total_checks;
	boot_mode_and_stop_control #(.RAM_BYTES(4), .EE_BYTES(4), .LONG_STAB(1'b0)) u_dut (
		.CLK, .RESET_N, .CE, .MODE_SELECT_PIN, .IRQ_HIGH_VOLTAGE, .CAPTURE_INPUT_ONE, .CAPTURE_INPUT_TWO,
		.BOOT_SELECT_LOW, .BOOT_SELECT_HIGH, .PORT_A, .PORT_B, .PORT_C, .EXT_IRQ, .WOR_IRQ, .CAN_IRQ,
		.CAN_ASLEEP, .SECURITY_BIT, .STOP_REQ, .SLOW_MODE_WRITE, .SLOW_MODE_DATA, .RX_VALID, .RX_DATA,
		.SINGLE_CHIP, .BOOT_MODE, .BOOT_FUNC, .CPU_HOLD, .START_VALID, .START_ADDR, .WAKE_STACK,
		.CLEAR_IMASK, .OSC_ENABLE, .SLOW_MODE_BIT, .INTERNAL_TICK, .CAN_TICK, .WATCHDOG_CLEAR,
		.EEPROM_READ_ONLY, .PERIPH_FREEZE, .IO_HOLD, .SCI_LOADER_CFG, .MEM_WE, .MEM_SEL, .MEM_ADDR,
		.MEM_WDATA, .LOADER_HALTED
	);
	board_host u_host (
		.CLK, .MODE_SELECT_PIN, .IRQ_HIGH_VOLTAGE, .CAPTURE_INPUT_ONE, .CAPTURE_INPUT_TWO,
		.BOOT_SELECT_LOW, .BOOT_SELECT_HIGH, .PORT_A, .PORT_B, .PORT_C, .RX_VALID, .RX_DATA
	);
	// Board supplies a clean external clock
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		if (MEM_WE === 1'b1) begin
			wq.push_back({MEM_SEL, MEM_ADDR, MEM_WDATA});
		end
	end
	task automatic wrap_up();
		$display("Checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// Capture waits for enabled edges, so a stalled enable delays it
	task automatic boot(input logic [5:0] p, input logic [23:0] abc, input logic sec);
		u_host.strap(p, abc);
		RESET_N <= 1'b0;
		SECURITY_BIT <= sec;
		repeat (16) @(posedge CLK);
		RESET_N <= 1'b1;
		CE <= 1'b0;
		wq.delete();
		repeat (6) @(posedge CLK);
		#1;
		chk({SINGLE_CHIP, BOOT_MODE}, 2'b00);
		@(posedge CLK);
		CE <= 1'b1;
	endtask : boot
	task automatic wait_start(output logic ok, output logic [15:0] a, output logic stk);
		ok = 1'b0;
		for (int i = 0; i < 100 && !ok; i++) begin
			@(posedge CLK);
			#1;
			ok = (START_VALID === 1'b1);
			a = START_ADDR;
			stk = WAKE_STACK;
		end
	endtask : wait_start
	task automatic t_single_stop();
		logic ok, stk;
		logic [15:0] a;
		int n, m;
		boot(6'h00, 24'h00_0000, 1'b1);
		wait_start(ok, a, stk);
		chk({ok, stk, SINGLE_CHIP, BOOT_MODE, a}, {4'b1010, RESET_VECTOR});
		u_host.strap(6'h2B, 24'hCC_0000);
		repeat (6) @(posedge CLK);
		STOP_REQ <= 1'b1;
		@(posedge CLK);
		STOP_REQ <= 1'b0;
		repeat (2) @(posedge CLK);
		#1;
		chk({SINGLE_CHIP, BOOT_MODE, OSC_ENABLE}, 3'h5);
		for (int i = 0; i < 3; i++) begin
			@(posedge CLK);
			CAN_ASLEEP <= 1'b1;
			SLOW_MODE_WRITE <= 1'b1;
			SLOW_MODE_DATA <= 1'b1;
			@(posedge CLK);
			SLOW_MODE_WRITE <= 1'b0;
			n = 0;
			m = 0;
			repeat (2) @(posedge CLK);
			repeat (64) begin
				@(posedge CLK);
				#1;
				n += (INTERNAL_TICK === 1'b1);
				m += (CAN_TICK === 1'b1);
			end
			chk(n, 4);
			chk(m, 64);
			@(posedge CLK);
			STOP_REQ <= 1'b1;
			@(posedge CLK);
			STOP_REQ <= 1'b0;
			#1;
			chk({OSC_ENABLE, CLEAR_IMASK, SLOW_MODE_BIT, WATCHDOG_CLEAR, EEPROM_READ_ONLY, PERIPH_FREEZE, IO_HOLD},
				7'h2F);
			repeat (4) @(posedge CLK);
			#1;
			chk({OSC_ENABLE, CPU_HOLD, SINGLE_CHIP}, 3'h3);
			@(posedge CLK);
			{CAN_IRQ, WOR_IRQ, EXT_IRQ} <= 3'h1 << i;
			for (int k = 0; k < 8 && OSC_ENABLE !== 1'b1; k++) begin
				@(posedge CLK);
				#1;
			end
			chk(OSC_ENABLE, 1'b1);
			@(posedge CLK);
			{CAN_IRQ, WOR_IRQ, EXT_IRQ} <= 3'h0;
			wait_start(ok, a, stk);
			chk({ok, stk, a}, {2'b11, IRQ_VECTOR});
		end
	endtask : t_single_stop
	task automatic t_loader();
		logic ok, stk;
		logic [15:0] a;
		logic [25:0] e;
		logic [7:0] b[4] = '{8'h03, 8'hA5, 8'h3C, 8'h77};
		boot(6'h2B, 24'hCC_0000, 1'b1);
		wait_start(ok, a, stk);
		chk({ok, BOOT_FUNC, SCI_LOADER_CFG, a}, {1'b1, 2'b11, 1'b1, LOADER_ROUTINE_START});
		chk(wq.size(), 9);
		for (int i = 0; i < 9; i++) begin
			e = (i < 4) ? {MEM_RAM, RAM_LOAD_BASE + 16'(i), RAM_CLEARED} :
				(i < 8) ? {MEM_EEPROM, EE_BASE_DEFAULT + 16'(i - 4), EE_ERASED} : {MEM_OPTION, 16'h0000, OPTION_CLEARED};
			chk(wq[i], e);
		end
		wq.delete();
		foreach (b[k]) begin
			u_host.send(b[k]);
		end
		repeat (4) @(posedge CLK);
		#1;
		chk({16'(wq.size()), LOADER_HALTED}, {16'd3, 1'b1});
		for (int i = 0; i < 3; i++) begin
			chk(wq[i], {MEM_RAM, RAM_LOAD_BASE + 16'(i), b[i]});
		end
	endtask : t_loader
	task automatic t_jump();
		logic ok, stk;
		logic [15:0] a;
		boot(6'h1A, 24'h00_0000, 1'b0);
		wait_start(ok, a, stk);
		chk({ok, SINGLE_CHIP, BOOT_MODE, BOOT_FUNC, a}, {3'b101, 2'b01, RAM_ENTRY});
		chk(wq.size(), 0);
		boot(6'h29, 24'hCC_1234, 1'b0);
		wait_start(ok, a, stk);
		chk({ok, SINGLE_CHIP, BOOT_MODE, BOOT_FUNC, a}, {3'b101, 2'b10, 16'h1234});
	endtask : t_jump
	task automatic t_refused();
		logic ok, stk;
		logic [15:0] a;
		logic [5:0] p[4] = '{6'h28, 6'h29, 6'h2F, 6'h23};
		logic [7:0] k[4] = '{8'hCC, 8'h33, 8'hCC, 8'hCC};
		for (int i = 0; i < 4; i++) begin
			boot(p[i], {k[i], 16'h1234}, 1'b0);
			wait_start(ok, a, stk);
			chk({ok, CPU_HOLD}, 2'b01);
		end
	endtask : t_refused
	initial begin
		repeat (5000) @(posedge CLK);
		err_count++;
		wrap_up();
	end
	initial begin
		{RESET_N, CE, EXT_IRQ, WOR_IRQ, CAN_IRQ, CAN_ASLEEP, SECURITY_BIT, STOP_REQ} = 8'h00;
		{SLOW_MODE_WRITE, SLOW_MODE_DATA} = 2'h0;
		err_count = 0;
		total_checks = 0;
		t_single_stop();
		t_loader();
		t_jump();
		t_refused();
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
